// ==== src/icr_pkg.sv ====
package icr_pkg;

    // ****************************************************************
    // data widths
    // ****************************************************************
    localparam int ICR_DW = 8;
    localparam int ICR_KW = 7;
    localparam int ICR_FIFO_DEPTH = 16;

    // ****************************************************************
    // external function word codes
    // ****************************************************************
    localparam logic [3:0] FN_SEL_KBD = 4'h1;
    localparam logic [3:0] FN_SEL_RDR = 4'h2;
    localparam logic [3:0] FN_SEL_PRT = 4'h3;
    localparam logic [3:0] FN_SEL_PUN = 4'h4;
    localparam logic [3:0] FN_SEL_PRT_PUN = 4'h5;
    localparam logic [3:0] FN_SEL_TOL = 4'h6;
    localparam logic [3:0] FN_STOP_IN = 4'h7;
    localparam logic [3:0] FN_STOP_OUT = 4'h8;

    // ****************************************************************
    // off-line copy routes
    // ****************************************************************
    localparam logic [2:0] RT_KBD_PRT = 3'h0;
    localparam logic [2:0] RT_KBD_PRT_PUN = 3'h1;
    localparam logic [2:0] RT_RDR_PUN = 3'h2;
    localparam logic [2:0] RT_RDR_PRT = 3'h3;
    localparam logic [2:0] RT_RDR_PRT_PUN = 3'h4;

    // ****************************************************************
    // destination mask bits and sources
    // ****************************************************************
    localparam int MB_PUN = 0;
    localparam int MB_PRT = 1;
    localparam int MB_TOL = 2;
    localparam logic [2:0] DM_NONE = 3'h0;
    localparam logic [2:0] DM_PUN = 3'h1;
    localparam logic [2:0] DM_PRT = 3'h2;
    localparam logic [2:0] DM_PRT_PUN = 3'h3;
    localparam logic [2:0] DM_TOL = 3'h4;
    localparam logic [1:0] SRC_HOST = 2'h0;
    localparam logic [1:0] SRC_KBD = 2'h1;
    localparam logic [1:0] SRC_RDR = 2'h2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef logic [2:0] icr_dmask_t;

    typedef enum logic [2:0] {
        IN_NONE = 3'b001,
        IN_KBD = 3'b010,
        IN_RDR = 3'b100
    } icr_in_e;

    typedef enum logic [4:0] {
        OUT_NONE = 5'b00001,
        OUT_PRT = 5'b00010,
        OUT_PUN = 5'b00100,
        OUT_BOTH = 5'b01000,
        OUT_TOL = 5'b10000
    } icr_out_e;

    typedef enum logic [3:0] {
        DS_IDLE = 4'b0001,
        DS_PUN = 4'b0010,
        DS_PRT = 4'b0100,
        DS_TOL = 4'b1000
    } icr_ds_e;

    typedef struct packed {
        logic valid;
        logic [ICR_DW-1:0] data;
    } icr_chr_s;

    typedef struct packed {
        logic valid;
        logic [ICR_KW-1:0] code;
    } icr_key_s;

    typedef struct packed {
        logic valid;
        logic [3:0] code;
    } icr_fn_s;

endpackage : icr_pkg

// ==== src/icr_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none

module icr_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    import icr_pkg::*;

    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic in_rdy;
        logic out_vld;
    } icr_fifo_s;

    icr_fifo_s st_r;
    icr_fifo_s st_nxt;
    logic push;
    logic pop;

    assign push = in_valid && st_r.in_rdy;
    assign pop = out_ready && st_r.out_vld;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == AW'(D - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rp = (st_r.rp == AW'(D - 1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
        // flags registered so both handshakes leave this module from flops
        st_nxt.in_rdy = (st_nxt.cnt != CW'(D));
        st_nxt.out_vld = (st_nxt.cnt != '0);
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign in_ready = st_r.in_rdy;
    assign out_valid = st_r.out_vld;
    assign out_data = st_r.mem[st_r.rp];

endmodule : icr_fifo

`default_nettype wire

// ==== src/icr_router.sv ====
// Operation
// R1: on-line, all host data and control words pass through this logic.
// R2: on-line, one input and one output function at once; printer plus punch allowed.
// R3: teletype link selectable only while all four local units are off-line.
// R4: each host function word is decoded into internal select and stop actions.
// R5: words are held in storage until their destination has taken them.
// R6: interrupt requests and acknowledges pass between console and host.
// R7: on-line keyboard characters go to the host and to the printer.
// R8: on-line printer takes characters from host and keyboard.
// R9: on-line reader frames are forwarded to the host.
// R10: on-line punch takes its data from the host.
// R11: off-line offers exactly five copy routes.
// R12: off-line printer takes keyboard or reader characters.
// R13: off-line keyboard characters route to printer and punch.
// R14: off-line keyboard routes start on key press; seven-bit code goes to printer.
// R15: keyboard to printer plus punch sends every code to both.
// R16: reader to punch copies frame by frame, any tape level.
// R17: off-line reader routes begin when the reader is enabled.
// R18: reader to punch stops itself after last frame with no feed holes.
// R19: reader to printer prints each frame then advances tape.
// R20: reader to printer ends itself when feed holes stop.
// R21: reader to printer plus punch: punch first, then print, then advance.
// R22: stored mode flag picks routing; reader advances only after all destinations accept.
`timescale 1ns/100ps
`default_nettype none

module icr_router #(
    parameter int DEPTH = icr_pkg::ICR_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic offline_sel,
    input wire logic [2:0] route_sel,
    input wire logic reader_enable,
    input wire logic [3:0] unit_offline,
    input wire icr_pkg::icr_fn_s host_fn,
    output logic fn_reject,
    input wire icr_pkg::icr_chr_s host_wr,
    output logic host_wr_ready,
    output icr_pkg::icr_chr_s host_rd,
    output logic [1:0] host_rd_src,
    input wire logic host_rd_ack,
    output logic host_int_req,
    input wire logic host_int_ack,
    input wire icr_pkg::icr_key_s kbd,
    output logic kbd_ready,
    input wire logic rdr_frame_valid,
    input wire logic rdr_feed_hole,
    input wire logic [icr_pkg::ICR_DW-1:0] rdr_data,
    output logic rdr_advance,
    output icr_pkg::icr_chr_s prt,
    input wire logic prt_done,
    output icr_pkg::icr_chr_s pun,
    input wire logic pun_done,
    output icr_pkg::icr_chr_s teletype_output_link,
    input wire logic tol_done,
    output logic offline_active,
    output logic copy_done
);
    import icr_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic offline;
        logic [2:0] route;
        icr_in_e in_fn;
        icr_out_e out_fn;
        icr_ds_e ds;
        icr_dmask_t dmask;
        logic [1:0] dsrc;
        logic [ICR_DW-1:0] ddata;
        icr_chr_s prt;
        icr_chr_s pun;
        icr_chr_s tol;
        icr_chr_s hin;
        logic [1:0] hin_src;
        logic int_req;
        logic fn_rej;
        logic rdr_run;
        logic rdr_en_prev;
        logic rdr_busy;
        logic rdr_drop;
        logic rdr_adv;
        logic rdr_ready;
        logic kbd_ready;
        logic copy_done;
    } icr_state_s;

    localparam icr_state_s ST_RST = '{
        in_fn: IN_NONE, out_fn: OUT_NONE, ds: DS_IDLE, default: '0};

    icr_state_s st_r;
    icr_state_s st_nxt;

    // ****************************************************************
    // decoding shared by dispatch launch and completion
    // ****************************************************************
    function automatic icr_ds_e next_ds(input icr_dmask_t m);
        // punch always before printer so a combined copy perforates first
        if (m[MB_PUN])
            return DS_PUN;
        else if (m[MB_PRT])
            return DS_PRT;
        else if (m[MB_TOL])
            return DS_TOL;
        else
            return DS_IDLE;
    endfunction : next_ds

    function automatic icr_dmask_t route_mask(input logic [2:0] rt);
        unique case (rt)
            RT_KBD_PRT, RT_RDR_PRT: return DM_PRT;
            RT_KBD_PRT_PUN, RT_RDR_PRT_PUN: return DM_PRT_PUN;
            RT_RDR_PUN: return DM_PUN;
            default: return DM_NONE;
        endcase
    endfunction : route_mask

    function automatic logic is_rdr_route(input logic [2:0] rt);
        return (rt == RT_RDR_PUN) || (rt == RT_RDR_PRT) || (rt == RT_RDR_PRT_PUN);
    endfunction : is_rdr_route

    // ****************************************************************
    // host data buffer
    // ****************************************************************
    logic fifo_ov;
    logic [ICR_DW-1:0] fifo_od;
    logic fifo_or;
    logic kbd_take;
    logic rdr_take;
    logic fifo_take;
    logic all_off;

    icr_fifo #(
        .W(ICR_DW),
        .D(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(host_wr.valid),
        .in_data(host_wr.data),
        .in_ready(host_wr_ready),
        .out_valid(fifo_ov),
        .out_data(fifo_od),
        .out_ready(fifo_or)
    );

    assign kbd_take = kbd.valid && st_r.kbd_ready;
    assign rdr_take = rdr_frame_valid && rdr_feed_hole && st_r.rdr_ready;
    assign all_off = &unit_offline;
    assign fifo_or = (st_r.ds == DS_IDLE) && !st_r.offline && (st_r.out_fn != OUT_NONE) && !kbd_take && !rdr_take;
    assign fifo_take = fifo_ov && fifo_or;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        icr_dmask_t lmask;
        icr_dmask_t rem;
        lmask = DM_NONE;
        rem = DM_NONE;
        st_nxt = st_r;
        st_nxt.fn_rej = 1'b0;
        st_nxt.rdr_adv = 1'b0;
        st_nxt.copy_done = 1'b0;
        st_nxt.rdr_en_prev = reader_enable;

        // mode is latched only when no dispatch, reader frame or held host word is in flight
        if (st_r.ds == DS_IDLE && !st_r.rdr_busy && !st_r.hin.valid && !st_r.rdr_run) // R22
        begin
            st_nxt.offline = offline_sel; // R22
            st_nxt.route = route_sel; // R11
        end

        // function translation
        if (host_fn.valid && !st_r.offline) // R4
        begin
            unique case (host_fn.code)
                FN_SEL_KBD, FN_SEL_RDR:
                begin
                    if (st_r.in_fn != IN_NONE) // R2
                        st_nxt.fn_rej = 1'b1;
                    else
                        st_nxt.in_fn = (host_fn.code == FN_SEL_KBD) ? IN_KBD : IN_RDR;
                end
                FN_SEL_PRT, FN_SEL_PUN, FN_SEL_PRT_PUN:
                begin
                    if (st_r.out_fn != OUT_NONE) // R2
                        st_nxt.fn_rej = 1'b1;
                    else if (host_fn.code == FN_SEL_PRT)
                        st_nxt.out_fn = OUT_PRT;
                    else if (host_fn.code == FN_SEL_PUN)
                        st_nxt.out_fn = OUT_PUN;
                    else
                        st_nxt.out_fn = OUT_BOTH; // R2
                end
                FN_SEL_TOL:
                begin
                    if (st_r.out_fn != OUT_NONE || !all_off) // R3
                        st_nxt.fn_rej = 1'b1;
                    else
                        st_nxt.out_fn = OUT_TOL;
                end
                FN_STOP_IN: st_nxt.in_fn = IN_NONE;
                FN_STOP_OUT: st_nxt.out_fn = OUT_NONE;
                default: st_nxt.fn_rej = 1'b1;
            endcase
        end
        else if (host_fn.valid)
        begin
            st_nxt.fn_rej = 1'b1;
        end
        if (st_r.out_fn == OUT_TOL && !all_off) // R3
            st_nxt.out_fn = OUT_NONE;

        // word held for the host until acknowledged
        if (st_r.hin.valid && host_rd_ack) // R5
        begin
            st_nxt.hin.valid = 1'b0;
            if (st_r.hin_src == SRC_RDR)
            begin
                st_nxt.rdr_adv = 1'b1; // R9
                st_nxt.rdr_busy = 1'b0;
                st_nxt.rdr_drop = 1'b1;
            end
        end

        // dispatch to local output units
        unique case (st_r.ds)
            DS_IDLE:
            begin
                if (kbd_take) // R14
                begin
                    st_nxt.ddata = {1'b0, kbd.code}; // R14
                    st_nxt.dsrc = SRC_KBD;
                    if (st_r.offline)
                        lmask = route_mask(st_r.route); // R13 R15
                    else
                    begin
                        lmask = DM_PRT; // R7 R8
                        st_nxt.hin = '{valid: 1'b1, data: {1'b0, kbd.code}}; // R7
                        st_nxt.hin_src = SRC_KBD;
                    end
                end
                else if (rdr_take)
                begin
                    st_nxt.ddata = rdr_data;
                    st_nxt.dsrc = SRC_RDR;
                    st_nxt.rdr_busy = 1'b1;
                    if (st_r.offline)
                        lmask = route_mask(st_r.route); // R16 R19 R21 R12
                    else
                    begin
                        st_nxt.hin = '{valid: 1'b1, data: rdr_data}; // R9
                        st_nxt.hin_src = SRC_RDR;
                    end
                end
                else if (fifo_take) // R1
                begin
                    st_nxt.ddata = fifo_od;
                    st_nxt.dsrc = SRC_HOST;
                    unique case (st_r.out_fn)
                        OUT_PRT: lmask = DM_PRT; // R8
                        OUT_PUN: lmask = DM_PUN; // R10
                        OUT_BOTH: lmask = DM_PRT_PUN; // R2
                        OUT_TOL: lmask = DM_TOL;
                        default: lmask = DM_NONE;
                    endcase
                end
                st_nxt.dmask = lmask;
                st_nxt.ds = next_ds(lmask);
            end
            DS_PUN, DS_PRT, DS_TOL:
            begin
                rem = st_r.dmask;
                if (st_r.ds == DS_PUN && pun_done)
                    rem[MB_PUN] = 1'b0;
                if (st_r.ds == DS_PRT && prt_done)
                    rem[MB_PRT] = 1'b0;
                if (st_r.ds == DS_TOL && tol_done)
                    rem[MB_TOL] = 1'b0;
                st_nxt.dmask = rem;
                st_nxt.ds = next_ds(rem); // R21
                if (rem == DM_NONE && st_r.dsrc == SRC_RDR && st_r.offline)
                begin
                    st_nxt.rdr_adv = 1'b1; // R22 R16 R19 R21
                    st_nxt.rdr_busy = 1'b0;
                    st_nxt.rdr_drop = 1'b1;
                end
            end
        endcase

        // a frame is not captured twice: wait for the reader to leave it
        if (st_r.rdr_drop && !rdr_frame_valid)
            st_nxt.rdr_drop = 1'b0;

        // off-line reader routes run from enable edge until feed holes end
        if (st_r.offline && is_rdr_route(st_r.route) && reader_enable && !st_r.rdr_en_prev) // R17
            st_nxt.rdr_run = 1'b1;
        if (st_r.rdr_run && !st_r.rdr_busy && st_r.ds == DS_IDLE && !st_r.rdr_drop && !rdr_feed_hole) // R18 R20
        begin
            st_nxt.rdr_run = 1'b0;
            st_nxt.copy_done = 1'b1;
        end
        if (!st_r.offline)
            st_nxt.rdr_run = 1'b0;

        // interrupt: new event wins over the acknowledge
        if (host_int_ack) // R6
            st_nxt.int_req = 1'b0;
        if ((st_nxt.hin.valid && !st_r.hin.valid) || st_nxt.fn_rej) // R6
            st_nxt.int_req = 1'b1;

        // unit handshakes and source readiness
        st_nxt.pun = '{valid: st_nxt.ds == DS_PUN, data: st_nxt.ddata};
        st_nxt.prt = '{valid: st_nxt.ds == DS_PRT, data: st_nxt.ddata};
        st_nxt.tol = '{valid: st_nxt.ds == DS_TOL, data: st_nxt.ddata};
        st_nxt.kbd_ready = (st_nxt.ds == DS_IDLE) && !st_nxt.hin.valid &&
            (st_nxt.offline ? !is_rdr_route(st_nxt.route) : (st_nxt.in_fn == IN_KBD));
        st_nxt.rdr_ready = (st_nxt.ds == DS_IDLE) && !st_nxt.hin.valid && !st_nxt.rdr_busy &&
            !st_nxt.rdr_drop && (st_nxt.offline ? st_nxt.rdr_run : (st_nxt.in_fn == IN_RDR));
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign fn_reject = st_r.fn_rej;
    assign host_rd = st_r.hin;
    assign host_rd_src = st_r.hin_src;
    assign host_int_req = st_r.int_req;
    assign kbd_ready = st_r.kbd_ready;
    assign rdr_advance = st_r.rdr_adv;
    assign prt = st_r.prt;
    assign pun = st_r.pun;
    assign teletype_output_link = st_r.tol;
    assign offline_active = st_r.offline;
    assign copy_done = st_r.copy_done;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_punch_first;
        @(posedge mclk) disable iff (!nrst)
        st_r.prt.valid |-> !st_r.dmask[MB_PUN];
    endproperty
    a_punch_first: assert property (p_punch_first) else $error("printer driven before punch finished"); // R21

    property p_adv_after_all;
        @(posedge mclk) disable iff (!nrst)
        (st_r.rdr_adv && st_r.offline) |-> ($past(st_r.ds) != DS_IDLE && st_r.ds == DS_IDLE);
    endproperty
    a_adv_after_all: assert property (p_adv_after_all) else $error("reader advanced with dispatch open"); // R22

    property p_tol_offline;
        @(posedge mclk) disable iff (!nrst)
        (st_r.out_fn == OUT_TOL) |-> $past(all_off);
    endproperty
    a_tol_offline: assert property (p_tol_offline) else $error("teletype link active with unit on-line"); // R3

    property p_one_input;
        @(posedge mclk) disable iff (!nrst)
        (host_fn.valid && host_fn.code == FN_SEL_KBD && st_r.in_fn == IN_RDR && !st_r.offline)
        |=> (fn_reject && st_r.in_fn == IN_RDR);
    endproperty
    a_one_input: assert property (p_one_input) else $error("second input function accepted"); // R2

    property p_kbd_online;
        @(posedge mclk) disable iff (!nrst)
        (kbd_take && !st_r.offline) |=> (host_rd.valid && prt.valid && prt.data == {1'b0, $past(kbd.code)});
    endproperty
    a_kbd_online: assert property (p_kbd_online) else $error("key not sent to host and printer"); // R7

    property p_kbd_both;
        @(posedge mclk) disable iff (!nrst)
        (kbd_take && st_r.offline && st_r.route == RT_KBD_PRT_PUN) |=> (pun.valid && st_r.dmask == DM_PRT_PUN);
    endproperty
    a_kbd_both: assert property (p_kbd_both) else $error("key not routed to punch and printer"); // R15

    property p_auto_stop;
        @(posedge mclk) disable iff (!nrst)
        (st_r.rdr_run && !st_r.rdr_busy && st_r.ds == DS_IDLE && !st_r.rdr_drop && !rdr_feed_hole)
        |=> (!st_r.rdr_run && copy_done) ##1 !copy_done;
    endproperty
    a_auto_stop: assert property (p_auto_stop) else $error("copy did not end at tape end"); // R18

    property p_int_on_word;
        @(posedge mclk) disable iff (!nrst)
        $rose(host_rd.valid) |-> host_int_req;
    endproperty
    a_int_on_word: assert property (p_int_on_word) else $error("no interrupt for word to host"); // R6

    property p_hold;
        @(posedge mclk) disable iff (!nrst)
        (host_rd.valid && !host_rd_ack) |=> (host_rd.valid && $stable(host_rd.data));
    endproperty
    a_hold: assert property (p_hold) else $error("held word lost before acknowledge"); // R5

endmodule : icr_router

`default_nettype wire

// ==== dv/icr_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// host computer model
// ****************************************************************
module icr_host_model (
    input wire logic mclk,
    input wire icr_pkg::icr_chr_s host_rd,
    input wire logic [1:0] host_rd_src,
    input wire logic host_int_req,
    input wire logic host_wr_ready,
    input wire logic fn_reject,
    output icr_pkg::icr_fn_s host_fn,
    output icr_pkg::icr_chr_s host_wr,
    output logic host_rd_ack,
    output logic host_int_ack
);
    import icr_pkg::*;
    int ack_delay = 2;
    logic [9:0] rx_q[$];
    initial {host_fn, host_wr, host_rd_ack, host_int_ack} = '0;
    // a slow acknowledge is what exposes a tape step taken too early
    always
    begin
        @(negedge mclk);
        host_int_ack = host_int_req === 1'b1;
        if (host_rd.valid === 1'b1)
        begin
            repeat (ack_delay) @(negedge mclk);
            rx_q.push_back({host_rd_src, host_rd.data});
            host_rd_ack = 1'b1;
            @(negedge mclk);
            host_rd_ack = 1'b0;
        end
    end
    task automatic send_fn(input logic [3:0] c, output logic rej);
        host_fn = '{1'b1, c};
        @(negedge mclk);
        rej = fn_reject;
        host_fn = '{1'b0, ~c};
        @(negedge mclk);
    endtask : send_fn
    // valid stays up after a refusal; caller drops it with quiet
    task automatic offer(input logic [7:0] d, output logic ok);
        host_wr = '{1'b1, d};
        ok = host_wr_ready;
        @(negedge mclk);
    endtask : offer
    task automatic quiet(input logic [7:0] d);
        host_wr = '{1'b0, ~d};
    endtask : quiet
endmodule : icr_host_model
`default_nettype wire

// ==== dv/icr_router_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module icr_router_bench;
    import icr_pkg::*;
    logic mclk = 0, nrst = 0, offline_sel = 0, reader_enable = 0, fn_reject, host_wr_ready, host_rd_ack;
    logic host_int_req, host_int_ack, kbd_ready, rdr_frame_valid = 0, rdr_feed_hole = 0, rdr_advance;
    logic prt_done = 0, pun_done = 0, tol_done = 0, offline_active, copy_done, r, ok;
    logic [2:0] route_sel = 0;
    logic [3:0] unit_offline = 0;
    logic [1:0] host_rd_src;
    logic [7:0] rdr_data = 0, d, w[32];
    logic [6:0] c;
    icr_fn_s host_fn;
    icr_chr_s host_wr, host_rd, prt, pun, teletype_output_link;
    icr_key_s kbd = 0;
    int miscompares = 0, samples_checked = 0, cycles = 0, n;
    icr_router uut (.*);
    icr_host_model host (.*);
    always #2.5 mclk = ~mclk;
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic give_verdict();
        if (miscompares == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic sig(input int s);
        return s == 0 ? rdr_advance : s == 1 ? copy_done : s == 2 ? host_rd.valid : s == 3 ? kbd_ready
            : host.rx_q.size() != 0;
    endfunction : sig
    function automatic icr_chr_s unit(input int u);
        return u == 0 ? pun : u == 1 ? prt : teletype_output_link;
    endfunction : unit
    task automatic waitp(input int s);
        int k = 0;
        while (sig(s) !== 1'b1 && k < 40)
        begin
            @(negedge mclk);
            k++;
        end
        chk(sig(s), 1);
    endtask : waitp
    // strict: printer must still be idle while the punch holds its word
    task automatic serve(input int u, input logic [7:0] e, input logic strict);
        int k = 0;
        do
        begin
            @(negedge mclk);
            k++;
        end
        while (unit(u).valid !== 1'b1 && k < 60);
        chk(unit(u), {1'b1, e});
        chk({strict & prt.valid, rdr_advance}, 0);
        {tol_done, prt_done, pun_done} = 3'h1 << u;
        @(negedge mclk);
        {pun_done, prt_done, tol_done} = 0;
    endtask : serve
    task automatic rst(input logic off, input logic [2:0] rt);
        nrst = 0;
        offline_sel = off;
        route_sel = rt;
        reader_enable = 0;
        repeat (3) @(negedge mclk);
        chk({host_wr_ready, prt.valid, pun.valid, host_rd.valid, host_int_req, rdr_advance, copy_done, kbd_ready,
            offline_active, teletype_output_link.valid}, 0);
        nrst = 1;
        repeat (2) @(negedge mclk);
        chk({host_wr_ready, offline_active}, {1'b1, off});
    endtask : rst
    task automatic key(input logic [6:0] k);
        kbd = '{1'b1, k};
        waitp(3);
        @(negedge mclk);
        kbd = '{1'b0, ~k};
    endtask : key
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h8b095e7a));
        @(negedge mclk);
        rst(0, 0);
        host.send_fn(FN_SEL_PRT_PUN, r);
        chk(r, 0);
        host.send_fn(FN_SEL_PUN, r);
        chk(r, 1);
        n = 0;
        ok = 1;
        while (ok && n < 24)
        begin
            w[n] = 8'($urandom);
            host.offer(w[n], ok);
            n += ok;
        end
        host.quiet(w[n]);
        chk({n == ICR_FIFO_DEPTH + 1, ok}, 2'h2);
        for (int i = 0; i < n; i++)
        begin
            serve(0, w[i], 1);
            serve(1, w[i], 0);
        end
        rst(0, 0);
        host.send_fn(FN_SEL_TOL, r);
        chk(r, 1);
        host.send_fn(4'hF, r);
        chk(r, 1);
        unit_offline = 4'hF;
        host.send_fn(FN_SEL_TOL, r);
        chk(r, 0);
        d = 8'($urandom);
        host.offer(d, ok);
        host.quiet(d);
        serve(2, d, 0);
        host.send_fn(FN_STOP_OUT, r);
        chk(r, 0);
        host.send_fn(FN_SEL_PRT, r);
        chk(r, 0);
        rst(0, 0);
        host.send_fn(FN_SEL_KBD, r);
        c = 7'($urandom);
        key(c);
        waitp(2);
        chk(host_int_req, 1);
        serve(1, {1'b0, c}, 0);
        waitp(4);
        chk(host.rx_q.pop_front(), {SRC_KBD, 1'b0, c});
        host.send_fn(FN_SEL_RDR, r);
        chk(r, 1);
        host.send_fn(FN_STOP_IN, r);
        host.send_fn(FN_SEL_RDR, r);
        chk(r, 0);
        host.ack_delay = 6;
        d = 8'($urandom);
        rdr_data = d;
        rdr_frame_valid = 1;
        rdr_feed_hole = 1;
        waitp(0);
        chk(host.rx_q.size(), 1);
        chk(host.rx_q.pop_front(), {SRC_RDR, d});
        rdr_frame_valid = 0;
        for (int rt = 0; rt < 5; rt++)
        begin
            rst(1, rt[2:0]);
            host.send_fn(FN_SEL_KBD, r);
            chk(r, 1);
            c = 7'($urandom);
            if (rt < 2)
                key(c);
            if (rt == 1)
                serve(0, {1'b0, c}, 0);
            if (rt < 2)
                serve(1, {1'b0, c}, 0);
            if (rt < 2)
                continue;
            reader_enable = 1;
            for (int f = 0; f < 3; f++)
            begin
                d = 8'($urandom);
                rdr_data = d;
                rdr_frame_valid = 1;
                rdr_feed_hole = 1;
                if (rt != 3)
                    serve(0, d, 1);
                if (rt != 2)
                    serve(1, d, 0);
                waitp(0);
                rdr_frame_valid = 0;
                rdr_data = ~d;
                rdr_feed_hole = f < 2;
                @(negedge mclk);
            end
            waitp(1);
        end
        chk(host.rx_q.size(), 0);
        give_verdict();
    end
endmodule : icr_router_bench
`default_nettype wire
